//--- pkg/rcv_pkg.sv
package rcv_pkg;

	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_CAUSE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_BEHAV = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_VECFG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_VESTAT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_SLPPWR = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PWRCTL = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_SLPEN = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_SRAMSZ = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_SWRST = 8'h20;

	// reset cause flag positions
	localparam int CAUSE_W = 8;
	localparam int cause_external_pin = 0;
	localparam int cause_power_on = 1;
	localparam int cause_brownout = 2;
	localparam int cause_watchdog_zero = 3;
	localparam int cause_software_request = 4;
	localparam int cause_watchdog_one = 5;
	localparam int cause_hibernation_wake = 6;
	localparam int cause_host_service_request = 7;
	localparam logic [CAUSE_W-1:0] CAUSE_POR_VAL = CAUSE_W'(1 << cause_power_on);

	// asynchronous event source indexes
	localparam int NSRC = 7;
	localparam int SRC_WD0 = 0;
	localparam int SRC_WD1 = 1;
	localparam int SRC_EXT = 2;
	localparam int SRC_HIB = 3;
	localparam int SRC_HSRV = 4;
	localparam int SRC_MBO = 5;
	localparam int SRC_ABO = 6;

	// reset behaviour: one bit per source, set means full power-on sequence
	localparam int BH_W = 4;
	localparam int BH_WD0 = 0;
	localparam int BH_WD1 = 1;
	localparam int BH_BOR = 2;
	localparam int BH_EXT = 3;
	localparam int BH_POR_LSB = 0;
	localparam int BH_SYS_LSB = 4;
	localparam logic [DATA_W-1:0] brownout_full_power_on_seq = DATA_W'(1 << (BH_POR_LSB + BH_BOR));
	localparam logic [DATA_W-1:0] brownout_system_reset = DATA_W'(1 << (BH_SYS_LSB + BH_BOR));

	// brown-out responses
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_INT = 2'h1,
		ACT_NMI = 2'h2,
		ACT_RST = 2'h3
	} bo_act_t;
	localparam int VE_ANALOG_LSB = 0;
	localparam int VE_MAIN_LSB = 2;
	localparam logic [DATA_W-1:0] analog_bo_no_action = DATA_W'(ACT_NONE) << VE_ANALOG_LSB;
	localparam logic [DATA_W-1:0] analog_bo_interrupt = DATA_W'(ACT_INT) << VE_ANALOG_LSB;
	localparam logic [DATA_W-1:0] analog_bo_nonmaskable = DATA_W'(ACT_NMI) << VE_ANALOG_LSB;
	localparam logic [DATA_W-1:0] analog_bo_reset = DATA_W'(ACT_RST) << VE_ANALOG_LSB;
	localparam logic [DATA_W-1:0] main_bo_no_action = DATA_W'(ACT_NONE) << VE_MAIN_LSB;
	localparam logic [DATA_W-1:0] main_bo_interrupt = DATA_W'(ACT_INT) << VE_MAIN_LSB;
	localparam logic [DATA_W-1:0] main_bo_nonmaskable = DATA_W'(ACT_NMI) << VE_MAIN_LSB;
	localparam logic [DATA_W-1:0] main_bo_reset = DATA_W'(ACT_RST) << VE_MAIN_LSB;

	// brown-out status flag positions
	localparam int VS_W = 2;
	localparam int main_rail_brownout_flag = 0;
	localparam int analog_rail_brownout_flag = 1;

	// sleep power fields
	localparam int SLP_FLASH_BIT = 0;
	localparam int SLP_SRAM_LSB = 1;
	localparam int SRAM_W = 2;
	localparam logic flash_sleep_full_power = 1'b0;
	localparam logic flash_sleep_reduced = 1'b1;
	localparam logic [SRAM_W-1:0] sram_sleep_full_power = 2'h0;
	localparam logic [SRAM_W-1:0] sram_sleep_standby = 2'h1;
	localparam logic [SRAM_W-1:0] sram_sleep_lowest = 2'h2;
	localparam logic [SRAM_W-1:0] SRAM_ILLEGAL = 2'h3;

	// power control and software reset bits
	localparam int PWR_GATE_BIT = 0;
	localparam int PWR_USBPLL_BIT = 1;
	localparam int SWRST_BIT = 0;

endpackage

//--- pkg/sync_if.sv
`timescale 1ns/1ps
// asynchronous levels in, one-cycle rising-edge pulses out
interface sync_if #(
	parameter int W = 1
);
	logic [W-1:0] raw;
	logic [W-1:0] rise;

	modport sync (input raw, output rise);
	modport user (output raw, input rise);
endinterface

//--- rtl/edge_sync.sv
`timescale 1ns/1ps
module edge_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// event lines
	sync_if.sync sif
);

	logic [W-1:0] meta_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;
	logic [W-1:0] rise_q;

	// three-stage synchroniser; first stage feeds only the second
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			meta_q <= sif.raw;
			s2_q <= meta_q;
			s3_q <= s2_q;
		end
	end

	// level moves only when stages two and three agree
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			lvl_q <= '0;
			rise_q <= '0;
		end else begin
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
			rise_q <= s2_q & s3_q & ~lvl_q;
		end
	end

	assign sif.rise = rise_q;

endmodule // edge_sync

//--- rtl/reset_cause_and_voltage_events.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module reset_cause_and_voltage_events
	import rcv_pkg::*;
#(
	parameter int NPERIPH = 8,
	parameter logic [DATA_W-1:0] SRAM_BYTES = 32'h0000_8000,
	parameter logic [BH_W-1:0] BEHAV_DEF = 4'h0
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	// asynchronous reset and brown-out sources
	input wire logic wdog_zero_rst_i,
	input wire logic wdog_one_rst_i,
	input wire logic ext_rst_b_i,
	input wire logic hib_wake_i,
	input wire logic host_srv_req_i,
	input wire logic main_bo_i,
	input wire logic analog_bo_i,
	// core sleep state
	input wire logic sleep_i,
	// reset requests
	output logic sys_rst_req_o,
	output logic por_req_o,
	// brown-out interrupts
	output logic bo_irq_o,
	output logic bo_nmi_o,
	// power controls
	output logic [NPERIPH-1:0] periph_clk_en_o,
	output logic [NPERIPH-1:0] periph_wake_en_o,
	output logic flash_sleep_lp_o,
	output logic [SRAM_W-1:0] sram_sleep_lvl_o,
	output logic usb_pll_pwr_o
);

	// write or read decode for one offset
	function automatic logic sel(input logic stb, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
		return stb && (a == o);
	endfunction

	logic [CAUSE_W-1:0] cause_q;
	logic [CAUSE_W-1:0] cause_set;
	logic [CAUSE_W-1:0] cause_clr;
	logic [VS_W-1:0] vstat_q;
	logic [VS_W-1:0] vstat_set;
	logic [VS_W-1:0] vstat_clr;
	logic [BH_W-1:0] behav_q;
	logic [BH_W-1:0] rst_hit;
	logic [BH_W-1:0] por_sel;
	logic [BH_W-1:0] sys_sel;
	bo_act_t main_act_q;
	bo_act_t analog_act_q;
	logic flash_q;
	logic [SRAM_W-1:0] sram_q;
	logic [SRAM_W-1:0] sram_wr;
	logic gate_q;
	logic pll_q;
	logic [NPERIPH-1:0] slpen_q;
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] rdata_q;
	logic sys_req_q;
	logic por_req_q;
	logic sys_req_d;
	logic por_req_d;
	logic sw_req;
	logic bo_rst_hit;
	logic cfg_rst;
	logic irq_q;
	logic nmi_q;
	logic [NPERIPH-1:0] clk_en_q;
	logic [NPERIPH-1:0] wake_en_q;
	logic flash_lp_q;
	logic [SRAM_W-1:0] sram_lvl_q;
	logic usb_pll_q;
	logic wr_cause;
	logic wr_behav;
	logic wr_vecfg;
	logic wr_vestat;
	logic wr_slppwr;
	logic wr_pwrctl;
	logic wr_slpen;
	logic wr_swrst;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// pin events pass the synchroniser; external pin is active low
	sync_if #(.W(NSRC)) src_if ();
	assign src_if.raw = {analog_bo_i, main_bo_i, host_srv_req_i, hib_wake_i, ~ext_rst_b_i, wdog_one_rst_i,
		wdog_zero_rst_i};

	edge_sync #(.W(NSRC)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.sif(src_if)
	);

	// write strobe decode
	assign wr_cause = sel(reg_wr_i, reg_addr_i, OFS_CAUSE);
	assign wr_behav = sel(reg_wr_i, reg_addr_i, OFS_BEHAV);
	assign wr_vecfg = sel(reg_wr_i, reg_addr_i, OFS_VECFG);
	assign wr_vestat = sel(reg_wr_i, reg_addr_i, OFS_VESTAT);
	assign wr_slppwr = sel(reg_wr_i, reg_addr_i, OFS_SLPPWR);
	assign wr_pwrctl = sel(reg_wr_i, reg_addr_i, OFS_PWRCTL);
	assign wr_slpen = sel(reg_wr_i, reg_addr_i, OFS_SLPEN);
	assign wr_swrst = sel(reg_wr_i, reg_addr_i, OFS_SWRST);

	// brown-out and reset events of this cycle
	assign sw_req = wr_swrst && reg_wdata_i[SWRST_BIT];
	assign bo_rst_hit = (src_if.rise[SRC_MBO] && main_act_q == ACT_RST)
		|| (src_if.rise[SRC_ABO] && analog_act_q == ACT_RST);

	// configurable reset sources and the kind each asks for
	always_comb begin
		rst_hit = '0;
		rst_hit[BH_WD0] = src_if.rise[SRC_WD0];
		rst_hit[BH_WD1] = src_if.rise[SRC_WD1];
		rst_hit[BH_BOR] = bo_rst_hit;
		rst_hit[BH_EXT] = src_if.rise[SRC_EXT];
		por_req_d = |(rst_hit & behav_q);
		sys_req_d = (|(rst_hit & ~behav_q)) || sw_req;
	end

	// one flag per origin
	always_comb begin
		cause_set = '0;
		cause_set[cause_watchdog_zero] = src_if.rise[SRC_WD0];
		cause_set[cause_watchdog_one] = src_if.rise[SRC_WD1];
		cause_set[cause_external_pin] = src_if.rise[SRC_EXT];
		cause_set[cause_hibernation_wake] = src_if.rise[SRC_HIB];
		cause_set[cause_host_service_request] = src_if.rise[SRC_HSRV];
		cause_set[cause_brownout] = bo_rst_hit;
		cause_set[cause_software_request] = sw_req;
	end

	// write-one-to-clear masks
	assign cause_clr = wr_cause ? reg_wdata_i[CAUSE_W-1:0] : '0;
	assign vstat_clr = wr_vestat ? reg_wdata_i[VS_W-1:0] : '0;

	// sticky causes; only power-on resets them, set beats clear
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cause_q <= CAUSE_POR_VAL;
		end else begin
			cause_q <= (cause_q & ~cause_clr) | cause_set;
		end
	end

	cause_sticky_a: assert property ($past(rst_b_i) |-> ~|($past(cause_q) & ~cause_q & ~$past(cause_clr)))
		else $error("cause flag dropped without a clear");
	cause_multi_a: assert property ((src_if.rise[SRC_EXT] && src_if.rise[SRC_HIB]) |=>
		(cause_q[cause_external_pin] && cause_q[cause_hibernation_wake]))
		else $error("simultaneous causes not all recorded");
	cause_mask_a: assert property ((wr_cause && cause_set == '0) |=>
		((cause_q | $past(reg_wdata_i[CAUSE_W-1:0])) == ($past(cause_q) | $past(reg_wdata_i[CAUSE_W-1:0]))))
		else $error("cause clear touched an unmasked flag");
	cause_reset_a: assert property (src_if.rise[SRC_WD1] |=> cause_q[cause_watchdog_one])
		else $error("watchdog one cause not set");

	// brown-out flags: only power-on or a software clear drops them
	always_comb begin
		vstat_set = '0;
		vstat_set[main_rail_brownout_flag] = src_if.rise[SRC_MBO];
		vstat_set[analog_rail_brownout_flag] = src_if.rise[SRC_ABO];
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			vstat_q <= '0;
		end else begin
			vstat_q <= (vstat_q & ~vstat_clr) | vstat_set;
		end
	end

	vstat_keep_a: assert property ($past(rst_b_i) |-> ~|($past(vstat_q) & ~vstat_q & ~$past(vstat_clr)))
		else $error("brown-out flag dropped without a clear");
	vstat_reset_a: assert property ((sys_rst_req_o && vstat_q[main_rail_brownout_flag] && !wr_vestat) |=>
		vstat_q[main_rail_brownout_flag])
		else $error("brown-out flag lost over a system reset");

	// reset request pulses; they also restore the configuration
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			sys_req_q <= 1'b0;
			por_req_q <= 1'b0;
		end else begin
			sys_req_q <= sys_req_d;
			por_req_q <= por_req_d;
		end
	end

	assign cfg_rst = !rst_b_i || sys_req_q || por_req_q;

	bo_kind_a: assert property ((src_if.rise[SRC_MBO] && main_act_q == ACT_RST && !sw_req) |=>
		(por_req_o == $past(behav_q[BH_BOR])) && (sys_rst_req_o == !$past(behav_q[BH_BOR])))
		else $error("brown-out reset of the wrong kind");
	sw_reset_a: assert property (sw_req |=> (sys_rst_req_o && cause_q[cause_software_request])
		##1 (behav_q == BEHAV_DEF && !gate_q))
		else $error("software reset sequence wrong");

	// reset behaviour: sources named in neither field keep their setting
	assign por_sel = reg_wdata_i[BH_POR_LSB +: BH_W];
	assign sys_sel = reg_wdata_i[BH_SYS_LSB +: BH_W];

	always_ff @(posedge sys_clk_i) begin
		if (cfg_rst) begin
			behav_q <= BEHAV_DEF;
		end else if (wr_behav) begin
			behav_q <= (behav_q & ~(por_sel | sys_sel)) | por_sel;
		end
	end

	behav_keep_a: assert property ((wr_behav && !cfg_rst && reg_wdata_i[BH_POR_LSB + BH_EXT] == 1'b0
		&& reg_wdata_i[BH_SYS_LSB + BH_EXT] == 1'b0) |=> behav_q[BH_EXT] == $past(behav_q[BH_EXT]))
		else $error("unselected reset source changed behaviour");

	// per-rail brown-out response
	always_ff @(posedge sys_clk_i) begin
		if (cfg_rst) begin
			main_act_q <= ACT_NONE;
			analog_act_q <= ACT_NONE;
		end else if (wr_vecfg) begin
			main_act_q <= bo_act_t'(reg_wdata_i[VE_MAIN_LSB +: 2]);
			analog_act_q <= bo_act_t'(reg_wdata_i[VE_ANALOG_LSB +: 2]);
		end
	end

	// interrupt levels follow the flag while its response is selected
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			irq_q <= 1'b0;
			nmi_q <= 1'b0;
		end else begin
			irq_q <= (vstat_q[main_rail_brownout_flag] && main_act_q == ACT_INT)
				|| (vstat_q[analog_rail_brownout_flag] && analog_act_q == ACT_INT);
			nmi_q <= (vstat_q[main_rail_brownout_flag] && main_act_q == ACT_NMI)
				|| (vstat_q[analog_rail_brownout_flag] && analog_act_q == ACT_NMI);
		end
	end

	bo_irq_a: assert property ((src_if.rise[SRC_ABO] && analog_act_q == ACT_INT && !cfg_rst && !wr_vecfg
		&& !wr_vestat) |=> ##1 bo_irq_o)
		else $error("analog brown-out interrupt missing");
	bo_nmi_a: assert property ((vstat_q[main_rail_brownout_flag] && main_act_q == ACT_NMI) |=> bo_nmi_o)
		else $error("main brown-out nmi missing");

	// sleep power settings; the unused sram code is ignored
	assign sram_wr = reg_wdata_i[SLP_SRAM_LSB +: SRAM_W];

	always_ff @(posedge sys_clk_i) begin
		if (cfg_rst) begin
			flash_q <= flash_sleep_full_power;
			sram_q <= sram_sleep_full_power;
		end else if (wr_slppwr) begin
			flash_q <= reg_wdata_i[SLP_FLASH_BIT];
			if (sram_wr != SRAM_ILLEGAL) begin
				sram_q <= sram_wr;
			end
		end
	end

	sram_code_a: assert property ((wr_slppwr && !cfg_rst && sram_wr == SRAM_ILLEGAL) |=> $stable(sram_q))
		else $error("illegal sram level accepted");

	// gating enable, usb pll power and sleep-enabled peripherals
	always_ff @(posedge sys_clk_i) begin
		if (cfg_rst) begin
			gate_q <= 1'b0;
			pll_q <= 1'b0;
			slpen_q <= '0;
		end else begin
			if (wr_pwrctl) begin
				gate_q <= reg_wdata_i[PWR_GATE_BIT];
				pll_q <= reg_wdata_i[PWR_USBPLL_BIT];
			end
			if (wr_slpen) begin
				slpen_q <= reg_wdata_i[NPERIPH-1:0];
			end
		end
	end

	// sleep-time power outputs; usb register access is never gated here
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			clk_en_q <= '1;
			wake_en_q <= '1;
			flash_lp_q <= 1'b0;
			sram_lvl_q <= sram_sleep_full_power;
			usb_pll_q <= 1'b0;
		end else begin
			clk_en_q <= (sleep_i && gate_q) ? slpen_q : '1;
			wake_en_q <= (sleep_i && gate_q) ? slpen_q : '1;
			flash_lp_q <= sleep_i && (flash_q == flash_sleep_reduced);
			sram_lvl_q <= sleep_i ? sram_q : sram_sleep_full_power;
			usb_pll_q <= pll_q;
		end
	end

	gating_a: assert property ((sleep_i && gate_q) |=> (periph_clk_en_o == $past(slpen_q)
		&& periph_wake_en_o == $past(slpen_q)))
		else $error("gated sleep enables wrong peripherals");
	no_gate_a: assert property ((!gate_q || !sleep_i) |=> &periph_clk_en_o)
		else $error("peripheral stopped without gating");

	// read mux; data stands one cycle after the strobe, zero otherwise
	always_comb begin
		rd_mux = '0;
		unique case (reg_addr_i)
			OFS_CAUSE: rd_mux = DATA_W'(cause_q);
			OFS_BEHAV: rd_mux = DATA_W'(behav_q);
			OFS_VECFG: rd_mux = (DATA_W'(main_act_q) << VE_MAIN_LSB) | (DATA_W'(analog_act_q) << VE_ANALOG_LSB);
			OFS_VESTAT: rd_mux = DATA_W'(vstat_q);
			OFS_SLPPWR: rd_mux = (DATA_W'(sram_q) << SLP_SRAM_LSB) | (DATA_W'(flash_q) << SLP_FLASH_BIT);
			OFS_PWRCTL: rd_mux = (DATA_W'(pll_q) << PWR_USBPLL_BIT) | (DATA_W'(gate_q) << PWR_GATE_BIT);
			OFS_SLPEN: rd_mux = DATA_W'(slpen_q);
			OFS_SRAMSZ: rd_mux = SRAM_BYTES;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= reg_rd_i ? rd_mux : '0;
		end
	end

	sram_size_a: assert property ((reg_rd_i && reg_addr_i == OFS_SRAMSZ) |=> reg_rdata_o == SRAM_BYTES)
		else $error("sram size read wrong");

	// main scenarios
	cover property (sw_req ##1 sys_rst_req_o);
	cover property (bo_rst_hit && behav_q[BH_BOR]);
	cover property (wr_cause && |cause_set);
	cover property (sleep_i && gate_q && |slpen_q);

	// outputs
	assign reg_rdata_o = rdata_q;
	assign sys_rst_req_o = sys_req_q;
	assign por_req_o = por_req_q;
	assign bo_irq_o = irq_q;
	assign bo_nmi_o = nmi_q;
	assign periph_clk_en_o = clk_en_q;
	assign periph_wake_en_o = wake_en_q;
	assign flash_sleep_lp_o = flash_lp_q;
	assign sram_sleep_lvl_o = sram_lvl_q;
	assign usb_pll_pwr_o = usb_pll_q;

endmodule // reset_cause_and_voltage_events

//--- verification/tb.sv
`timescale 1ns/1ps
module tb import rcv_pkg::*; ;
	// clock, reset and bench drive
	logic clk;
	logic rst_b;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic wr;
	logic rd;
	logic [NSRC-1:0] ev_q;
	logic slp_q;
	// design outputs
	logic sys_req;
	logic por_req;
	logic irq;
	logic nmi;
	logic [7:0] clk_en;
	logic [7:0] wake_en;
	logic flash_lp;
	logic [SRAM_W-1:0] sram_lvl;
	logic usb;
	// verdict counters and behavioural register model
	int err_count;
	int n_checks;
	logic [7:0] cause_m;
	logic [7:0] slpen_m;
	logic [1:0] vestat_m;
	logic [1:0] pwr_m;
	logic [3:0] behav_m;
	logic [3:0] vecfg_m;
	logic [2:0] slp_m;

	reset_cause_and_voltage_events u_reset_cause_and_voltage_events (
		.sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .wdog_zero_rst_i(ev_q[SRC_WD0]), .wdog_one_rst_i(ev_q[SRC_WD1]),
		.ext_rst_b_i(~ev_q[SRC_EXT]), .hib_wake_i(ev_q[SRC_HIB]), .host_srv_req_i(ev_q[SRC_HSRV]),
		.main_bo_i(ev_q[SRC_MBO]), .analog_bo_i(ev_q[SRC_ABO]), .sleep_i(slp_q), .sys_rst_req_o(sys_req),
		.por_req_o(por_req), .bo_irq_o(irq), .bo_nmi_o(nmi), .periph_clk_en_o(clk_en),
		.periph_wake_en_o(wake_en), .flash_sleep_lp_o(flash_lp), .sram_sleep_lvl_o(sram_lvl),
		.usb_pll_pwr_o(usb)
	);

	// 25 mhz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wrap_up();
		if (err_count == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// config registers back to defaults, causes and flags kept
	task cfg_def();
		behav_m = 4'h0;
		vecfg_m = 4'h0;
		slp_m = 3'h0;
		pwr_m = 2'h0;
		slpen_m = 8'h0;
	endtask

	task rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask

	// one write cycle, then the model follows it
	task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		case (a)
			OFS_CAUSE: cause_m = cause_m & ~d[7:0];
			OFS_BEHAV: behav_m = (behav_m & ~d[7:4]) | d[3:0];
			OFS_VECFG: vecfg_m = d[3:0];
			OFS_VESTAT: vestat_m = vestat_m & ~d[1:0];
			OFS_SLPPWR: begin
				slp_m[0] = d[SLP_FLASH_BIT];
				if (d[2:1] != SRAM_ILLEGAL) slp_m[2:1] = d[2:1];
			end
			OFS_PWRCTL: pwr_m = d[1:0];
			OFS_SLPEN: slpen_m = d[7:0];
			OFS_SWRST: if (d[SWRST_BIT]) begin
				cause_m[cause_software_request] = 1'b1;
				cfg_def();
			end
			default: ;
		endcase
	endtask

	// steady outputs against the model
	task check_outs();
		logic [7:0] en;
		logic irq_e;
		logic nmi_e;
		repeat (2) @(posedge clk);
		@(negedge clk);
		en = (slp_q && pwr_m[PWR_GATE_BIT]) ? slpen_m : 8'hff;
		irq_e = (vestat_m[main_rail_brownout_flag] && vecfg_m[VE_MAIN_LSB+:2] == ACT_INT) ||
			(vestat_m[analog_rail_brownout_flag] && vecfg_m[VE_ANALOG_LSB+:2] == ACT_INT);
		nmi_e = (vestat_m[main_rail_brownout_flag] && vecfg_m[VE_MAIN_LSB+:2] == ACT_NMI) ||
			(vestat_m[analog_rail_brownout_flag] && vecfg_m[VE_ANALOG_LSB+:2] == ACT_NMI);
		chk(32'({clk_en, wake_en}), 32'({en, en}));
		chk(32'(flash_lp), 32'(slp_q && slp_m[0]));
		chk(32'(sram_lvl), 32'(slp_q ? slp_m[2:1] : 2'h0));
		chk(32'(usb), 32'(pwr_m[PWR_USBPLL_BIT]));
		chk(32'({irq, nmi}), 32'({irq_e, nmi_e}));
		chk(32'({sys_req, por_req}), 32'h0);
	endtask

	// raise event pins, count request pulses, then release and let them re-arm
	task ev(input logic [NSRC-1:0] m);
		int ns;
		int np;
		logic req;
		logic kind;
		ns = 0;
		np = 0;
		req = 1'b0;
		kind = 1'b0;
		@(posedge clk);
		ev_q <= m;
		for (int i = 0; i < 9; i++) begin
			@(negedge clk);
			ns += int'(sys_req === 1'b1);
			np += int'(por_req === 1'b1);
		end
		@(posedge clk);
		ev_q <= '0;
		repeat (6) @(posedge clk);
		if (m[SRC_WD0]) begin
			cause_m[cause_watchdog_zero] = 1'b1;
			req = 1'b1;
			kind = behav_m[BH_WD0];
		end
		if (m[SRC_WD1]) begin
			cause_m[cause_watchdog_one] = 1'b1;
			req = 1'b1;
			kind = behav_m[BH_WD1];
		end
		if (m[SRC_EXT]) begin
			cause_m[cause_external_pin] = 1'b1;
			req = 1'b1;
			kind = behav_m[BH_EXT];
		end
		if (m[SRC_HIB]) cause_m[cause_hibernation_wake] = 1'b1;
		if (m[SRC_HSRV]) cause_m[cause_host_service_request] = 1'b1;
		if (m[SRC_MBO]) vestat_m[main_rail_brownout_flag] = 1'b1;
		if (m[SRC_ABO]) vestat_m[analog_rail_brownout_flag] = 1'b1;
		if ((m[SRC_MBO] && vecfg_m[VE_MAIN_LSB+:2] == ACT_RST) ||
			(m[SRC_ABO] && vecfg_m[VE_ANALOG_LSB+:2] == ACT_RST)) begin
			cause_m[cause_brownout] = 1'b1;
			req = 1'b1;
			kind = behav_m[BH_BOR];
		end
		chk(32'(ns), 32'(req && !kind));
		chk(32'(np), 32'(req && kind));
		if (req) cfg_def();
		check_outs();
	endtask

	// main sequence
	initial begin
		logic [7:0] m;
		rst_b = 1'b0;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		ev_q = '0;
		slp_q = 1'b0;
		err_count = 0;
		n_checks = 0;
		void'($urandom(17071));
		cause_m = CAUSE_POR_VAL;
		vestat_m = 2'h0;
		cfg_def();
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		check_outs();
		rchk(OFS_CAUSE, 32'(CAUSE_POR_VAL));
		rchk(OFS_VESTAT, 32'h0);
		rchk(OFS_BEHAV, 32'h0);
		rchk(OFS_SRAMSZ, 32'h0000_8000);
		rchk(8'h24, 32'h0);
		rchk(OFS_SWRST, 32'h0);
		// behaviour writes: unselected kept, both selects give power-on
		wr_reg(OFS_BEHAV, 32'h0000_0001);
		wr_reg(OFS_BEHAV, brownout_full_power_on_seq);
		rchk(OFS_BEHAV, 32'(behav_m));
		wr_reg(OFS_BEHAV, 32'h0000_00ff);
		wr_reg(OFS_BEHAV, 32'h0000_0020);
		rchk(OFS_BEHAV, 32'(behav_m));
		// random behaviour per watchdog and external pin source, then its event
		for (int i = 0; i < 6; i++) begin
			wr_reg(OFS_BEHAV, $urandom & 32'hff);
			rchk(OFS_BEHAV, 32'(behav_m));
			ev(NSRC'(1) << (i % 3 == 0 ? SRC_WD0 : (i % 3 == 1 ? SRC_WD1 : SRC_EXT)));
			rchk(OFS_CAUSE, 32'(cause_m));
			rchk(OFS_BEHAV, 32'(behav_m));
		end
		// coinciding events all show together
		ev((NSRC'(1) << SRC_EXT) | (NSRC'(1) << SRC_HIB) | (NSRC'(1) << SRC_HSRV));
		rchk(OFS_CAUSE, 32'(cause_m));
		m = 8'($urandom);
		wr_reg(OFS_CAUSE, 32'(m));
		rchk(OFS_CAUSE, 32'(cause_m));
		wr_reg(OFS_CAUSE, 32'h0000_00ff);
		rchk(OFS_CAUSE, 32'(cause_m));
		ev(NSRC'(1) << SRC_WD0);
		rchk(OFS_CAUSE, 32'(cause_m));
		// every action on each rail, partial flag clears
		for (int r = 0; r < 2; r++) begin
			for (int a = 0; a < 4; a++) begin
				wr_reg(OFS_BEHAV, r ? brownout_full_power_on_seq : brownout_system_reset);
				wr_reg(OFS_VECFG, 32'(a) << (r ? VE_MAIN_LSB : VE_ANALOG_LSB));
				rchk(OFS_VECFG, 32'(vecfg_m));
				ev(NSRC'(1) << (r ? SRC_MBO : SRC_ABO));
				rchk(OFS_VESTAT, 32'(vestat_m));
				rchk(OFS_CAUSE, 32'(cause_m));
				wr_reg(OFS_VESTAT, r ? 32'h2 : 32'h1);
				rchk(OFS_VESTAT, 32'(vestat_m));
				check_outs();
			end
		end
		// sleep gating, flash and sram levels, usb pll
		wr_reg(OFS_SLPEN, $urandom & 32'hff);
		rchk(OFS_SLPEN, 32'(slpen_m));
		for (int g = 0; g < 2; g++) begin
			for (int c = 0; c < 8; c++) begin
				wr_reg(OFS_PWRCTL, 32'(g) | (32'(c % 2) << PWR_USBPLL_BIT));
				wr_reg(OFS_SLPPWR, 32'(c));
				@(posedge clk);
				slp_q <= (c != 0);
				check_outs();
				rchk(OFS_SLPPWR, 32'(slp_m));
			end
		end
		@(posedge clk);
		slp_q <= 1'b0;
		// software reset keeps causes and brown-out flags
		wr_reg(OFS_PWRCTL, 32'h3);
		wr_reg(OFS_SWRST, 32'h1);
		@(negedge clk);
		chk(32'({sys_req, por_req}), 32'h2);
		rchk(OFS_CAUSE, 32'(cause_m));
		rchk(OFS_VESTAT, 32'(vestat_m));
		rchk(OFS_PWRCTL, 32'(pwr_m));
		rchk(OFS_SLPEN, 32'(slpen_m));
		check_outs();
		// power-on leaves only the power-on cause and clears the brown-out flags
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		cause_m = CAUSE_POR_VAL;
		vestat_m = 2'h0;
		cfg_def();
		rchk(OFS_CAUSE, 32'(cause_m));
		rchk(OFS_VESTAT, 32'(vestat_m));
		wrap_up();
	end
endmodule // tb
